// *** verilog/pic_pkg.sv ***
// Package for the priority interrupt controller: map, resets, carriers
`default_nettype none
package pic_pkg;

  // ==========================================================
  // Register map (byte offsets on the plain register port)
  localparam logic [7:0] REG_CTRL_OFF    = 8'h00;
  localparam logic [7:0] REG_SENSE_OFF   = 8'h01;
  localparam logic [7:0] REG_ENABLE_OFF  = 8'h02;
  localparam logic [7:0] REG_KEYMASK_OFF = 8'h03;
  localparam logic [7:0] REG_PEND_OFF    = 8'h04;
  localparam logic [7:0] REG_VEC_OFF     = 8'h05;

  // ==========================================================
  // Field positions and values after reset
  localparam int         NMI_EDGE_BIT   = 0;
  localparam logic [7:0] CTRL_RST       = 8'h00;
  localparam logic [7:0] SENSE_RST      = 8'h00;
  localparam logic [7:0] ENABLE_RST     = 8'h00;
  localparam logic [7:0] KEY_MASK_RST   = 8'hbf;
  localparam logic [7:0] WAKE_LINES     = 8'h47;

  // ==========================================================
  // Vector numbers and counts
  localparam logic [5:0] VEC_NMI        = 6'h03;
  localparam logic [5:0] VEC_EXT_BASE   = 6'h04;
  localparam logic [5:0] VEC_INT_BASE   = 6'h0c;
  localparam int         NUM_LINES      = 8;
  localparam int         NUM_PERIPH     = 26;
  localparam int         ACK_STAGE_CLRS = 1;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_bus_s;

  typedef struct packed {
    logic        valid;
    logic [5:0]  vector;
    logic [15:0] table_addr;
  } cpu_req_s;

  // Table entries are 16-bit words
  function automatic logic [15:0] vec_table_addr(input logic [5:0] vec);
    vec_table_addr = {9'h000, vec, 1'b0};
  endfunction

endpackage
`default_nettype wire

// *** verilog/prio_pick.sv ***
// Fixed priority picker: lowest set index wins
`timescale 1ns/1ns
`default_nettype none
module prio_pick
  import pic_pkg::*;
#(
  parameter int W  = 8,
  parameter int IW = (W > 1) ? $clog2(W) : 1
) (
  input  wire logic [W-1:0]  req_in,
  output logic               valid_out,
  output logic [IW-1:0]      index_out
);

  // ==========================================================
  // Scan from the top so the lowest index is left standing
  always_comb begin
    valid_out = |req_in;
    index_out = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (req_in[i]) begin
        index_out = IW'(i);
      end
    end
  end

endmodule
`default_nettype wire

// *** verilog/ext_line_detect.sv ***
// Per-line falling-edge capture and pending flags for external lines
`timescale 1ns/1ns
`default_nettype none
module ext_line_detect
  import pic_pkg::*;
#(
  parameter int N = NUM_LINES
) (
  input  wire logic         sys_clk_in,
  input  wire logic         reset_n_in,
  input  wire logic [N-1:0] low_in,
  input  wire logic [N-1:0] sense_in,
  input  wire logic [N-1:0] enable_in,
  input  wire logic [N-1:0] ack_in,
  input  wire logic         mask_bit_in,
  output logic [N-1:0]      edge_out,
  output logic [N-1:0]      pend_out
);

  logic [N-1:0] low_prev_q;
  logic [N-1:0] clr;

  // ==========================================================
  // Edge detect on already synchronised levels
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      low_prev_q <= '0;
    end else begin
      low_prev_q <= low_in;
    end
  end

  assign edge_out = low_in & ~low_prev_q;
  // Pending survives an enable clear; cleared by ack or mask+level+off
  assign clr = ack_in | ({N{mask_bit_in}} & ~sense_in & ~enable_in);

  // ==========================================================
  // New edge wins over a clear in the same cycle
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend_out <= '0;
    end else begin
      pend_out <= (pend_out & ~clr) | (edge_out & sense_in & enable_in);
    end
  end

endmodule
`default_nettype wire

// *** verilog/priority_interrupt_controller.sv ***
// Priority interrupt controller top: pins, registers, arbitration, CPU hand-off
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module priority_interrupt_controller
  import pic_pkg::*;
#(
  parameter int NPER = NUM_PERIPH
) (
  input  wire logic                 sys_clk_in,
  input  wire logic                 reset_n_in,
  input  wire reg_bus_s             reg_bus_in,
  output logic [7:0]                reg_rdata_out,
  input  wire logic                 nmi_n_in,
  input  wire logic [NUM_LINES-1:0] line_n_in,
  input  wire logic [NUM_LINES-1:0] key_sense_input_n_in,
  input  wire logic [NPER-1:0]      periph_req_in,
  input  wire logic [NPER-1:0]      periph_en_in,
  input  wire logic                 mask_bit_in,
  input  wire logic                 cpu_ack_in,
  input  wire logic                 hw_standby_in,
  input  wire logic                 soft_standby_in,
  output cpu_req_s                  cpu_req_out,
  output logic                      wake_out
);

  localparam int PIW = (NPER > 1) ? $clog2(NPER) : 1;

  // ==========================================================
  // Register file
  logic [7:0]           ctrl_q;
  logic [7:0]           line_sense_control_q;
  logic [7:0]           line_enable_register_q;
  logic [7:0]           key_sense_mask_q;
  logic                 nonmaskable_edge_select;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_q                 <= CTRL_RST;
      line_sense_control_q   <= SENSE_RST;
      line_enable_register_q <= ENABLE_RST;
      key_sense_mask_q       <= KEY_MASK_RST;
    end else if (reg_bus_in.wr) begin
      case (reg_bus_in.addr)
        REG_CTRL_OFF:    ctrl_q <= reg_bus_in.wdata & 8'h01;
        REG_SENSE_OFF:   line_sense_control_q   <= reg_bus_in.wdata;
        REG_ENABLE_OFF:  line_enable_register_q <= reg_bus_in.wdata;
        REG_KEYMASK_OFF: key_sense_mask_q       <= reg_bus_in.wdata;
        default: begin
        end
      endcase
    end
  end

  assign nonmaskable_edge_select = ctrl_q[NMI_EDGE_BIT];

  // ==========================================================
  // Pin synchronisers; first stage feeds only the second
  logic                 nmi_s1_q;
  logic                 nmi_s2_q;
  logic                 nmi_prev_q;
  logic [NUM_LINES-1:0] line_s1_q;
  logic [NUM_LINES-1:0] line_s2_q;
  logic [NUM_LINES-1:0] key_s1_q;
  logic [NUM_LINES-1:0] key_s2_q;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      nmi_s1_q   <= 1'b1;
      nmi_s2_q   <= 1'b1;
      nmi_prev_q <= 1'b1;
      line_s1_q  <= '1;
      line_s2_q  <= '1;
      key_s1_q   <= '1;
      key_s2_q   <= '1;
    end else begin
      nmi_s1_q   <= nmi_n_in;
      nmi_s2_q   <= nmi_s1_q;
      nmi_prev_q <= nmi_s2_q;
      // Pad level read whatever the port direction is
      line_s1_q  <= line_n_in;
      line_s2_q  <= line_s1_q;
      key_s1_q   <= key_sense_input_n_in;
      key_s2_q   <= key_s1_q;
    end
  end

  // ==========================================================
  // Key sense merge onto line six
  logic                 key_hit;
  logic [NUM_LINES-1:0] line_low;

  assign key_hit = |(~key_s2_q & ~key_sense_mask_q);

  always_comb begin
    line_low    = ~line_s2_q;
    line_low[6] = ~line_s2_q[6] | key_hit;
  end

  // ==========================================================
  // Nonmaskable edge capture
  logic nmi_edge;
  logic nmi_pend_q;
  logic ack_nmi;

  // Rising when select is 1, falling when 0
  assign nmi_edge = nonmaskable_edge_select ?
                    (nmi_s2_q & ~nmi_prev_q) :
                    (~nmi_s2_q & nmi_prev_q);
  assign ack_nmi  = cpu_ack_in & cpu_req_out.valid &
                    (cpu_req_out.vector == VEC_NMI);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      nmi_pend_q <= 1'b0;
    end else if (hw_standby_in) begin
      nmi_pend_q <= 1'b0;
    end else begin
      // Edge in the ack cycle is kept
      nmi_pend_q <= nmi_edge | (nmi_pend_q & ~ack_nmi);
    end
  end

  // ==========================================================
  // External lines
  logic [NUM_LINES-1:0] line_edge;
  logic [NUM_LINES-1:0] line_pend;
  logic [NUM_LINES-1:0] line_ack;
  logic [NUM_LINES-1:0] ext_req;
  logic                 ext_valid;
  logic [2:0]           ext_idx;

  ext_line_detect #(
    .N (NUM_LINES)
  ) u_detect (
    .sys_clk_in  (sys_clk_in),
    .reset_n_in  (reset_n_in),
    .low_in      (line_low),
    .sense_in    (line_sense_control_q),
    .enable_in   (line_enable_register_q),
    .ack_in      (line_ack),
    .mask_bit_in (mask_bit_in),
    .edge_out    (line_edge),
    .pend_out    (line_pend)
  );

  always_comb begin
    line_ack = '0;
    if (cpu_ack_in && cpu_req_out.valid &&
        cpu_req_out.vector >= VEC_EXT_BASE &&
        cpu_req_out.vector < VEC_INT_BASE) begin
      line_ack[3'(cpu_req_out.vector - VEC_EXT_BASE)] = 1'b1;
    end
  end

  // Level lines need the enable; edge pendings were gated on capture
  assign ext_req = (line_sense_control_q & line_pend) |
                   (~line_sense_control_q & line_low &
                    line_enable_register_q);

  // ==========================================================
  // First decision state for external and nonmaskable requests
  logic [NUM_LINES-1:0] ext_stage_q;
  logic                 nmi_stage_q;

  // Snapshot keeps a request alive one state past its enable clear
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_stage_q <= '0;
      nmi_stage_q <= 1'b0;
    end else if (cpu_ack_in) begin
      ext_stage_q <= '0;
      nmi_stage_q <= 1'b0;
    end else begin
      ext_stage_q <= ext_req;
      nmi_stage_q <= nmi_pend_q & ~hw_standby_in;
    end
  end

  // ==========================================================
  // Final decision: nonmaskable, then lines, then peripherals
  logic [NUM_LINES-1:0] ext_go;
  logic [NPER-1:0]      int_go;
  logic                 int_valid;
  logic [PIW-1:0]       int_idx;
  cpu_req_s             req_d;
  cpu_req_s             req_q;

  assign ext_go = ext_stage_q & {NUM_LINES{~mask_bit_in}};
  assign int_go = periph_req_in & periph_en_in &
                  {NPER{~mask_bit_in}};

  prio_pick #(
    .W (NUM_LINES)
  ) u_ext_pick (
    .req_in    (ext_go),
    .valid_out (ext_valid),
    .index_out (ext_idx)
  );

  prio_pick #(
    .W (NPER)
  ) u_int_pick (
    .req_in    (int_go),
    .valid_out (int_valid),
    .index_out (int_idx)
  );

  always_comb begin
    req_d = '0;
    if (nmi_stage_q) begin
      req_d.valid  = 1'b1;
      req_d.vector = VEC_NMI;
    end else if (ext_valid) begin
      req_d.valid  = 1'b1;
      req_d.vector = VEC_EXT_BASE + 6'(ext_idx);
    end else if (int_valid) begin
      req_d.valid  = 1'b1;
      req_d.vector = VEC_INT_BASE + 6'(int_idx);
    end
    req_d.table_addr = vec_table_addr(req_d.vector);
  end

  // Held each state until the CPU takes it at an instruction end
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_q <= '0;
    end else if (cpu_ack_in) begin
      req_q <= '0;
    end else begin
      req_q <= req_d;
    end
  end

  assign cpu_req_out = req_q;

  // ==========================================================
  // Software standby wake
  logic wake_q;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= soft_standby_in &
                (nmi_edge | (|(ext_req & WAKE_LINES)));
    end
  end

  assign wake_out = wake_q;

  // ==========================================================
  // Register read port, data one cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_bus_in.rd) begin
      case (reg_bus_in.addr)
        REG_CTRL_OFF:    reg_rdata_out <= ctrl_q;
        REG_SENSE_OFF:   reg_rdata_out <= line_sense_control_q;
        REG_ENABLE_OFF:  reg_rdata_out <= line_enable_register_q;
        REG_KEYMASK_OFF: reg_rdata_out <= key_sense_mask_q;
        REG_PEND_OFF:    reg_rdata_out <= line_pend;
        REG_VEC_OFF:     reg_rdata_out <= {req_q.valid, 1'b0, req_q.vector};
        default:         reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_KEYMASK_RESET: assert property (
    $rose(reset_n_in) |-> key_sense_mask_q == KEY_MASK_RST)
    else $error("key mask reset value wrong");

  AST_MASK_GATES: assert property (
    (cpu_req_out.valid && cpu_req_out.vector != VEC_NMI) |->
      !$past(mask_bit_in))
    else $error("maskable request passed while masked");

  AST_NMI_TWO_STATES: assert property (
    (nmi_pend_q && !hw_standby_in && !cpu_ack_in) ##1
    (nmi_pend_q && !hw_standby_in && !cpu_ack_in) |=>
      cpu_req_out.valid && cpu_req_out.vector == VEC_NMI)
    else $error("nonmaskable not presented with vector 3");

  AST_TABLE_ADDR: assert property (
    cpu_req_out.table_addr == {9'h000, cpu_req_out.vector, 1'b0})
    else $error("table address not twice the vector");

  AST_INT_ONE_STATE: assert property (
    (int_go[0] && !nmi_stage_q && ext_stage_q == '0 && !mask_bit_in &&
     !cpu_ack_in) |=> cpu_req_out.valid &&
      cpu_req_out.vector == VEC_INT_BASE)
    else $error("internal request not presented next state");

  AST_LINE0_WINS: assert property (
    (ext_stage_q[0] && ext_stage_q[7] && !nmi_stage_q && !mask_bit_in &&
     !cpu_ack_in) |=> cpu_req_out.vector == VEC_EXT_BASE)
    else $error("line 0 did not win arbitration");

  AST_PEND_CLEAR: assert property (
    (mask_bit_in && !line_sense_control_q[0] &&
     !line_enable_register_q[0]) |=> !line_pend[0])
    else $error("edge pending not cleared");

  AST_KEY_TO_LINE6: assert property (
    (key_hit && !line_sense_control_q[6] && line_enable_register_q[6] &&
     !cpu_ack_in) |=> ext_stage_q[6])
    else $error("key input did not raise line 6");

  AST_WAKE: assert property (
    (soft_standby_in && nmi_edge) |=> wake_out)
    else $error("no wake from nonmaskable edge");

  COV_NMI: cover property (ack_nmi);
  COV_LINE_EDGE: cover property (|(line_edge & line_sense_control_q));
  COV_INT: cover property (cpu_req_out.valid &&
                           cpu_req_out.vector >= VEC_INT_BASE);
  COV_KEY: cover property (key_hit ##2 cpu_req_out.valid);

endmodule
`default_nettype wire

// *** tb/cpu_core_model.sv ***
// Behavioural CPU core: waits, acknowledges, latches vector, masks
`timescale 1ns/1ns
`default_nettype none
module cpu_core_model
  import pic_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire cpu_req_s   req_in,
  input  wire logic [2:0] delay_in,
  input  wire logic       rte_in,
  output logic            ack_out,
  output logic            mask_out,
  output logic            taken_out,
  output logic [5:0]      vector_out,
  output logic [15:0]     table_addr_out
);
  // ==========================================================
  // Exception sequence
  // Mask set at once, not after stacking: keeps level lines quiet
  localparam int SEQ_STATES = 14;
  logic [4:0] busy_q;
  logic [2:0] wait_q;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_q         <= 5'h00;
      wait_q         <= 3'h0;
      ack_out        <= 1'b0;
      mask_out       <= 1'b0;
      taken_out      <= 1'b0;
      vector_out     <= 6'h00;
      table_addr_out <= 16'h0000;
    end else begin
      ack_out   <= 1'b0;
      taken_out <= 1'b0;
      if (rte_in) begin
        mask_out <= 1'b0; // Even byte reloads the mask
      end
      if (ack_out) begin
        vector_out     <= req_in.vector; // Latched at the ack edge
        table_addr_out <= req_in.table_addr;
        taken_out      <= req_in.valid;
        mask_out       <= 1'b1;
        busy_q         <= 5'(SEQ_STATES); // Stack, fetch, process
      end else if (busy_q != 5'h00) begin
        busy_q <= busy_q - 5'h01;
      end else if (req_in.valid) begin
        if (wait_q >= delay_in) begin
          ack_out <= 1'b1; // After current instruction
          wait_q  <= 3'h0;
        end else begin
          wait_q <= wait_q + 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/priority_interrupt_controller_bench.sv ***
// Self-checking bench for the priority interrupt controller
`timescale 1ns/1ns
`default_nettype none
module priority_interrupt_controller_bench import pic_pkg::*;;
  logic        sys_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  reg_bus_s    bus        = '0;
  logic        nmi_n      = 1'b1;
  logic [7:0]  line_n     = 8'hff;
  logic [7:0]  key_n      = 8'hff;
  logic [25:0] preq       = '0;
  logic [25:0] pen        = '0;
  logic        soft_sb    = 1'b0;
  logic        hw_sb      = 1'b0;
  logic [2:0]  dly        = 3'h0;
  logic        return_from_exception        = 1'b0;
  logic        rd_p       = 1'b0;
  logic [15:0] seed       = 16'h5076;
  logic [7:0]  rdata;
  logic        ack, mask, taken, wake;
  cpu_req_s    req;
  logic [5:0]  vec;
  logic [15:0] taddr;
  int          n_fail     = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  logic [5:0]  vq[$];
  logic [7:0]  rq[$];

  always #4 sys_clk_in = ~sys_clk_in;

  priority_interrupt_controller #(.NPER(26)) priority_interrupt_controller_i (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .reg_bus_in(bus),
    .reg_rdata_out(rdata), .nmi_n_in(nmi_n), .line_n_in(line_n),
    .key_sense_input_n_in(key_n), .periph_req_in(preq),
    .periph_en_in(pen), .mask_bit_in(mask), .cpu_ack_in(ack),
    .hw_standby_in(hw_sb), .soft_standby_in(soft_sb),
    .cpu_req_out(req), .wake_out(wake));

  cpu_core_model cpu_core_model_i (
    .clk_in(sys_clk_in), .reset_n_in(reset_n_in), .req_in(req),
    .delay_in(dly), .rte_in(return_from_exception), .ack_out(ack), .mask_out(mask),
    .taken_out(taken), .vector_out(vec), .table_addr_out(taddr));

  // ==========================================================
  // Helpers
  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction

  task automatic check(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // One gap cycle after each strobe keeps drivers single per step
  task automatic access(input logic [7:0] a, d, input logic w);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    cycles(1);
    bus <= '0;
    cycles(1);
  endtask

  task automatic rd(input logic [7:0] a, e);
    rq.push_back(e);
    access(a, 8'h00, 1'b0);
  endtask

  task automatic ret();
    return_from_exception <= 1'b1;
    cycles(1);
    return_from_exception <= 1'b0;
    cycles(1);
  endtask

  task automatic pulse(input logic [7:0] m);
    line_n <= m; // Pins left as inputs
    cycles(4);
    line_n <= 8'hff;
    cycles(4);
  endtask

  task automatic expect_vec(input logic [5:0] v);
    vq.push_back(v);
    dly <= 3'(xs());
    for (int k = 0; k < 100 && vq.size() != 0; k++) cycles(1);
    check("vector wait", 16'h0000, 16'(vq.size()));
  endtask

  // ==========================================================
  // Result monitor
  always @(posedge sys_clk_in) begin
    rd_p <= bus.rd;
    if (rd_p) check("rdata", 16'(rq.pop_front()), 16'(rdata));
    if (taken) begin
      if (vq.size() == 0) check("stray vector", 16'hffff, 16'(vec));
      else begin
        check("vector", 16'(vq[0]), 16'(vec));
        check("table", {9'h000, vq.pop_front(), 1'b0}, taddr);
      end
    end
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    logic [7:0] r;
    int         idx;
    cycles(5);
    reset_n_in <= 1'b1;
    cycles(3);
    rd(REG_KEYMASK_OFF, 8'hbf);
    rd(REG_CTRL_OFF, 8'h00);
    rd(8'h10, 8'h00);
    nmi_n <= 1'b0;
    cycles(5);
    rd(REG_VEC_OFF, 8'h83); // Valid with vector 3 at c5
    expect_vec(6'h03);
    nmi_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      access(REG_ENABLE_OFF, 8'h01 << i, 1'b1);
      line_n <= ~(8'h01 << i);
      cycles(20); // Held while masked
      ret();
      expect_vec(6'(4 + i));
      line_n <= 8'hff;
      cycles(4);
    end
    access(REG_CTRL_OFF, 8'hff, 1'b1);
    rd(REG_CTRL_OFF, 8'h01); // Upper bits dropped
    nmi_n <= 1'b0;
    cycles(20); // Falling edge now ignored
    nmi_n <= 1'b1;
    expect_vec(6'h03);
    hw_sb <= 1'b1;
    nmi_n <= 1'b0;
    cycles(4);
    nmi_n <= 1'b1;
    cycles(20); // Rising edge in hardware standby dropped
    hw_sb <= 1'b0;
    cycles(10);
    access(REG_ENABLE_OFF, 8'hff, 1'b1);
    line_n <= 8'h7e;
    cycles(6);
    ret();
    expect_vec(6'h04);
    line_n <= 8'h7f;
    cycles(4);
    ret();
    expect_vec(6'h0b);
    line_n <= 8'hff;
    r = 8'(xs());
    access(REG_KEYMASK_OFF, r, 1'b1);
    rd(REG_KEYMASK_OFF, r);
    access(REG_KEYMASK_OFF, 8'hfb, 1'b1);
    access(REG_ENABLE_OFF, 8'h40, 1'b1);
    key_n <= 8'hf7;
    ret();
    cycles(20); // Blocked key stays silent
    key_n <= 8'hf3;
    expect_vec(6'h0a);
    key_n <= 8'hff;
    access(REG_SENSE_OFF, 8'h02, 1'b1);
    access(REG_ENABLE_OFF, 8'h02, 1'b1);
    rd(REG_SENSE_OFF, 8'h02);
    rd(REG_ENABLE_OFF, 8'h02);
    pulse(8'hfd);
    ret();
    expect_vec(6'h05);
    pulse(8'hfd);
    rd(REG_PEND_OFF, 8'h02);
    access(REG_ENABLE_OFF, 8'h00, 1'b1); // Kept under mask while line 1 is still edge-sensed
    rd(REG_PEND_OFF, 8'h02);
    access(REG_SENSE_OFF, 8'h00, 1'b1);
    rd(REG_PEND_OFF, 8'h00);
    ret();
    cycles(20);
    idx = 1 + int'(xs() % 16'd25);
    pen <= 26'h1 << idx;
    preq <= (26'h1 << idx) | 26'h1;
    expect_vec(6'(12 + idx));
    pen <= pen | 26'h1;
    ret();
    expect_vec(6'h0c); // Source 0 outranks
    preq <= '0;
    soft_sb <= 1'b1;
    access(REG_ENABLE_OFF, 8'h09, 1'b1);
    line_n <= 8'hf7;
    cycles(6);
    check("wake", 16'h0000, 16'(wake));
    line_n <= 8'hf6;
    cycles(6);
    check("wake", 16'h0001, 16'(wake));
    line_n <= 8'hff;
    cycles(4);
    nmi_n <= 1'b0;
    cycles(4);
    nmi_n <= 1'b1;
    expect_vec(6'h03); // Rising edge wakes and is served
    conclude();
  end
endmodule
`default_nettype wire
